// file: hdl/hbac_pkg.sv
// Constants for the host bus address capture front end.
// Assumes a single clk_sys_i domain; host pins are already synchronous.
//
// Function
// - Device answers only while chip select asserted
// - Non-mux FIFO select routes access to data FIFOs
// - Non-mux address from five address lines
// - Sixteen-bit non-mux ignores address bit zero
// - Eight-bit non-mux ignores, disables upper data
// - Single-phase mux: both bytes in one phase
// - Dual-phase mux: both bytes on low lines
// - Eight-bit dual-phase disables upper shared lines
// - Latch on deasserting edge, polarity by strap
// - Read and write strobes, strap polarity
// - Direction plus enable strobe style
package hbac_pkg;

  // ---------------------------------------------------------------
  // Address modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    HBAC_NONMUX = 2'h0,
    HBAC_MUX_SINGLE = 2'h1,
    HBAC_MUX_DUAL = 2'h2
  } hbac_mode_e;

  // ---------------------------------------------------------------
  // Widths and field positions
  // ---------------------------------------------------------------
  localparam int HBAC_NM_ADDR_W = 5;
  localparam int HBAC_MUX_ADDR_W = 16;
  localparam int HBAC_DATA_W = 16;
  localparam int HBAC_LO_MSB = 7;
  localparam int HBAC_HI_LSB = 8;

  // ---------------------------------------------------------------
  // Reset values and default polarities (0 = active low)
  // ---------------------------------------------------------------
  localparam logic [15:0] HBAC_ADDR_RST = 16'h0000;
  localparam logic [15:0] HBAC_DATA_RST = 16'h0000;
  localparam logic HBAC_POL_RST = 1'h0;
  localparam logic HBAC_WIDE_RST = 1'h1;

endpackage : hbac_pkg

// file: hdl/hbac_host_bus_address_capture.sv
// Host bus front end: selection, address capture, strobe decode, data lanes.
// Assumes all host pins are synchronous to clk_sys_i and strap levels are
// stable around reset release.
`timescale 1ns/100ps
module hbac_host_bus_address_capture
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Straps
  input wire logic select_polarity_config_i,
  input wire logic latch_polarity_config_i,
  input wire logic read_dir_polarity_config_i,
  input wire logic write_strobe_polarity_config_i,
  input wire logic wide_data_config_i,
  input wire logic [1:0] addr_mode_config_i,
  input wire logic dir_enable_style_config_i,
  // Host pins
  input wire logic chip_select_i,
  input wire logic fifo_window_select_i,
  input wire logic [4:0] addr_i,
  input wire logic upper_byte_latch_enable_i,
  input wire logic lower_byte_latch_enable_i,
  input wire logic read_dir_i,
  input wire logic write_strobe_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic [15:0] data_oe_o,
  // Internal side
  input wire logic [15:0] rd_data_i,
  output logic [15:0] addr_o,
  output logic fifo_access_o,
  output logic rd_o,
  output logic wr_o,
  output logic [15:0] wr_data_o
);

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  logic cs_pol_reg;
  logic ale_pol_reg;
  logic rd_pol_reg;
  logic wr_pol_reg;
  logic wide_reg;
  logic dir_style_reg;
  hbac_pkg::hbac_mode_e mode_reg;
  logic strap_done_reg;

  // Taken once at first edge after release, then frozen
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      strap_done_reg <= 1'b0;
      cs_pol_reg <= hbac_pkg::HBAC_POL_RST;
      ale_pol_reg <= hbac_pkg::HBAC_POL_RST;
      rd_pol_reg <= hbac_pkg::HBAC_POL_RST;
      wr_pol_reg <= hbac_pkg::HBAC_POL_RST;
      wide_reg <= hbac_pkg::HBAC_WIDE_RST;
      dir_style_reg <= 1'b0;
      mode_reg <= hbac_pkg::HBAC_NONMUX;
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      cs_pol_reg <= select_polarity_config_i;
      ale_pol_reg <= latch_polarity_config_i;
      rd_pol_reg <= read_dir_polarity_config_i;
      wr_pol_reg <= write_strobe_polarity_config_i;
      wide_reg <= wide_data_config_i;
      dir_style_reg <= dir_enable_style_config_i;
      mode_reg <= hbac_pkg::hbac_mode_e'(addr_mode_config_i);
    end
  end

  // ---------------------------------------------------------------
  // Strobe decode
  // ---------------------------------------------------------------
  // Select ignored until straps are taken, so no bogus access at start
  wire selected = strap_done_reg & (chip_select_i ^ ~cs_pol_reg);
  wire ale_hi_act = upper_byte_latch_enable_i ^ ~ale_pol_reg;
  wire ale_lo_act = lower_byte_latch_enable_i ^ ~ale_pol_reg;
  wire rd_pin_act = read_dir_i ^ ~rd_pol_reg;
  wire wr_pin_act = write_strobe_i ^ ~wr_pol_reg;
  wire dir_is_read = read_dir_i ^ rd_pol_reg;
  wire rd_act = dir_style_reg ? (wr_pin_act & dir_is_read) : rd_pin_act;
  wire wr_act = dir_style_reg ? (wr_pin_act & ~dir_is_read) : wr_pin_act;
  wire rd_phase = selected & rd_act;
  wire wr_phase = selected & wr_act;
  wire is_mux = (mode_reg != hbac_pkg::HBAC_NONMUX);
  wire is_dual = (mode_reg == hbac_pkg::HBAC_MUX_DUAL);
  wire upper_off = ~wide_reg & (~is_mux | is_dual);

  // ---------------------------------------------------------------
  // Address latch enable edge detect
  // ---------------------------------------------------------------
  logic ale_hi_reg;
  logic ale_lo_reg;
  logic [15:0] mux_addr_reg;
  logic [15:0] mux_addr_next;
  wire hi_fall = ale_hi_reg & ~ale_hi_act;
  wire lo_fall = ale_lo_reg & ~ale_lo_act;
  wire [7:0] hi_byte = data_i[15:hbac_pkg::HBAC_HI_LSB];
  wire [7:0] lo_byte = data_i[hbac_pkg::HBAC_LO_MSB:0];

  // Byte loads per mux mode
  always_comb
  begin
    mux_addr_next = mux_addr_reg;
    if (is_dual && hi_fall)
    begin
      mux_addr_next[15:8] = lo_byte;
    end
    if (lo_fall)
    begin
      if (is_dual)
      begin
        mux_addr_next[7:0] = lo_byte;
      end
      else
      begin
        mux_addr_next = {hi_byte, lo_byte};
      end
    end
  end

  // Previous enable levels and captured address
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      ale_hi_reg <= 1'b0;
      ale_lo_reg <= 1'b0;
      mux_addr_reg <= hbac_pkg::HBAC_ADDR_RST;
    end
    else
    begin
      ale_hi_reg <= ale_hi_act & is_mux;
      ale_lo_reg <= ale_lo_act & is_mux;
      mux_addr_reg <= mux_addr_next;
    end
  end

  // ---------------------------------------------------------------
  // Address and data out to the core
  // ---------------------------------------------------------------
  logic [15:0] addr_reg;
  logic fifo_reg;
  logic rd_reg;
  logic wr_reg;
  logic [15:0] wr_data_reg;
  logic [15:0] dout_reg;
  logic [15:0] oe_reg;

  // Bit 0 dropped in 16-bit mode so byte pairs share one word address
  wire [4:0] nm_addr = wide_reg ? {addr_i[4:1], 1'b0} : addr_i;
  wire [15:0] addr_next = is_mux ? mux_addr_next : {11'h000, nm_addr};
  // FIFO window exists only with dedicated address lines
  wire fifo_sel = ~is_mux & fifo_window_select_i;
  wire fifo_next = fifo_sel & (rd_phase | wr_phase);
  // Unused upper lanes read as zero instead of floating into the core
  wire [15:0] wr_lanes = upper_off ? {8'h00, data_i[7:0]} : data_i;
  wire [15:0] wr_data_next = wr_phase ? wr_lanes : wr_data_reg;
  wire [15:0] dout_next = upper_off ? {8'h00, rd_data_i[7:0]} : rd_data_i;
  // Drivers on only for a selected read; unused upper byte stays off
  wire [15:0] oe_lanes = upper_off ? 16'h00ff : 16'hffff;
  wire [15:0] oe_next = rd_phase ? oe_lanes : 16'h0000;

  // Address and FIFO routing, one cycle behind the pins
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      addr_reg <= hbac_pkg::HBAC_ADDR_RST;
      fifo_reg <= 1'b0;
    end
    else
    begin
      addr_reg <= addr_next;
      fifo_reg <= fifo_next;
    end
  end

  // Strobe levels covering the data phase; no pulse shaping
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
    end
    else
    begin
      rd_reg <= rd_phase;
      wr_reg <= wr_phase;
    end
  end

  // Data lanes and drivers; read data lags the core by one cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      wr_data_reg <= hbac_pkg::HBAC_DATA_RST;
      dout_reg <= hbac_pkg::HBAC_DATA_RST;
      oe_reg <= 16'h0000;
    end
    else
    begin
      wr_data_reg <= wr_data_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // All outputs straight from flip-flops
  assign addr_o = addr_reg;
  assign fifo_access_o = fifo_reg;
  assign rd_o = rd_reg;
  assign wr_o = wr_reg;
  assign wr_data_o = wr_data_reg;
  assign data_o = dout_reg;
  assign data_oe_o = oe_reg;

endmodule // hbac_host_bus_address_capture

// file: dv/hbac_chk.sv
// Port checker for the host bus front end.
// Assumes straps stay steady outside reset.
`timescale 1ns/100ps
module hbac_chk
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic select_polarity_config_i,
  input wire logic latch_polarity_config_i,
  input wire logic lower_byte_latch_enable_i,
  input wire logic [15:0] data_i,
  input wire logic read_dir_polarity_config_i,
  input wire logic write_strobe_polarity_config_i,
  input wire logic wide_data_config_i,
  input wire logic [1:0] addr_mode_config_i,
  input wire logic dir_enable_style_config_i,
  input wire logic chip_select_i,
  input wire logic [4:0] addr_i,
  input wire logic read_dir_i,
  input wire logic write_strobe_i,
  input wire logic [15:0] data_oe_o,
  input wire logic [15:0] addr_o,
  input wire logic fifo_access_o,
  input wire logic rd_o,
  input wire logic wr_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // Decoded strobes; meaning of the two pins follows the style strap
  wire logic cs = chip_select_i == select_polarity_config_i;
  wire logic en = write_strobe_i == write_strobe_polarity_config_i;
  wire logic dr = read_dir_i != read_dir_polarity_config_i;
  wire logic rs = cs && (dir_enable_style_config_i ? en && dr : !dr);
  wire logic ws = cs && en && !(dir_enable_style_config_i && dr);
  wire logic nm = addr_mode_config_i == hbac_pkg::HBAC_NONMUX;
  wire logic lo_act = lower_byte_latch_enable_i == latch_polarity_config_i;
  // Low latch pulse: active level, then released
  sequence s_lo_pulse;
    lo_act ##1 !lo_act;
  endsequence
  a_single_latch: assert property ((addr_mode_config_i == 2'h1) ##0 s_lo_pulse |=>
    addr_o == $past(data_i)) else $error("single phase address");
  a_read_strobe: assert property (rs |=> rd_o) else $error("read missed");
  a_write_strobe: assert property (ws |=> wr_o) else $error("write missed");
  a_unsel_quiet: assert property (!cs |=> !wr_o) else $error("unselected write");
  a_read_drive: assert property (!rs |=> !rd_o && data_oe_o == 16'h0) else $error("drive");
  a_narrow_upper: assert property (!wide_data_config_i &&
    (addr_mode_config_i == 2'h0 || addr_mode_config_i == 2'h2) |->
    data_oe_o[15:8] == 8'h0) else $error("upper lanes driven");
  a_wide_bit0: assert property (nm && wide_data_config_i |-> !addr_o[0]) else $error("bit0");
  a_mux_no_fifo: assert property (!nm |-> !fifo_access_o) else $error("fifo in mux");
  a_nonmux_addr: assert property (nm && ws |=> addr_o[4:1] == $past(addr_i[4:1]))
    else $error("address lines");
endmodule // hbac_chk
bind hbac_host_bus_address_capture hbac_chk chk_u (.*);

// file: dv/hbac_host.sv
// Host controller model: select, strobes, latch pulses, address/data bus.
// Assumes all strobes and latches at their low-active default polarity.
`timescale 1ns/100ps
module hbac_host
(
  input wire logic clk_sys_i,
  input wire logic sty_i,
  output logic cs_o,
  output logic fifo_o,
  output logic [4:0] addr_o,
  output logic hi_o,
  output logic lo_o,
  output logic rd_o,
  output logic wr_o,
  output logic [15:0] bus_o
);
  // Idle levels; released address and data lines show the inverse of their last value
  initial {cs_o, fifo_o, hi_o, lo_o, rd_o, wr_o, addr_o, bus_o} = {6'h2f, 21'h0};
  task automatic acc(input logic r, s, f, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    cs_o <= !s;
    {fifo_o, addr_o, bus_o} <= {f, a, d};
    rd_o <= sty_i ? r : !r;
    wr_o <= sty_i ? 1'b0 : r;
    @(posedge clk_sys_i);
    {cs_o, rd_o, wr_o, addr_o, bus_o} <= {3'h7, ~a, ~d};
  endtask
  // Address phase: byte held through the releasing edge of the latch
  task automatic lat(input logic h, input logic [15:0] d);
    @(posedge clk_sys_i);
    {hi_o, lo_o, bus_o} <= {!h, h, d};
    @(posedge clk_sys_i);
    {hi_o, lo_o} <= 2'h3;
    @(posedge clk_sys_i);
    bus_o <= ~d;
  endtask
endmodule // hbac_host

// file: dv/tb_top.sv
// Self-checking bench: four strap setups driven through the host model.
// Assumes checker and host model are compiled first.
`timescale 1ns/100ps
module tb_top;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, wide_data_config_i = 1'b1;
  logic dir_enable_style_config_i = 1'b0;
  logic select_polarity_config_i = 1'b0, latch_polarity_config_i = 1'b0;
  logic read_dir_polarity_config_i = 1'b0, write_strobe_polarity_config_i = 1'b0;
  logic [1:0] addr_mode_config_i = 2'h0;
  logic fifo_window_select_i, fifo_access_o, rd_o, wr_o;
  logic h_cs, h_hi, h_lo, h_rd, h_wr;
  // Host model speaks default polarity; the straps invert what the pins carry
  wire logic chip_select_i = h_cs ^ select_polarity_config_i;
  wire logic upper_byte_latch_enable_i = h_hi ^ latch_polarity_config_i;
  wire logic lower_byte_latch_enable_i = h_lo ^ latch_polarity_config_i;
  wire logic read_dir_i = h_rd ^ read_dir_polarity_config_i;
  wire logic write_strobe_i = h_wr ^ write_strobe_polarity_config_i;
  logic [4:0] addr_i;
  logic [15:0] data_o, data_oe_o, addr_o, wr_data_o, bus, rd_data_i = 16'h5aa5;
  wire logic [15:0] data_i = (data_oe_o & data_o) | (~data_oe_o & bus);
  int errors = 0, checks = 0;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  hbac_host_bus_address_capture dut_u (.*);
  hbac_host host_u (.clk_sys_i, .sty_i(dir_enable_style_config_i), .cs_o(h_cs),
    .fifo_o(fifo_window_select_i), .addr_o(addr_i), .hi_o(h_hi),
    .lo_o(h_lo), .rd_o(h_rd), .wr_o(h_wr), .bus_o(bus));
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    errors += int'(seen !== exp);
    if (seen !== exp) $display("Error %s expected %h seen %h", nm, exp, seen);
  endtask
  // Straps change only under reset; first access two edges after release
  task automatic rst(input logic [1:0] m, input logic w, s, p);
    @(posedge clk_sys_i);
    {rstn_i, addr_mode_config_i, wide_data_config_i, dir_enable_style_config_i} <= {1'b0, m, w, s};
    {select_polarity_config_i, latch_polarity_config_i} <= {p, p};
    {read_dir_polarity_config_i, write_strobe_polarity_config_i} <= {p, p};
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
  endtask
  task automatic t_nonmux();
    rst(2'h0, 1'b1, 1'b0, 1'b0);
    host_u.acc(1'b0, 1'b1, 1'b0, 5'h13, 16'hc3a7);
    #1 chk("addr_o", addr_o, 16'h0012);
    chk("wr_o", 16'(wr_o), 16'h1);
    chk("wr_data_o", wr_data_o, 16'hc3a7);
    host_u.acc(1'b1, 1'b1, 1'b0, 5'h0b, 16'h0);
    #1 chk("data_oe_o", data_oe_o, 16'hffff);
    chk("rd_o", 16'(rd_o), 16'h1);
    chk("data_o", data_o, 16'h5aa5);
    host_u.acc(1'b1, 1'b1, 1'b1, 5'h05, 16'h0);
    #1 chk("fifo_access_o", 16'(fifo_access_o), 16'h1);
    host_u.acc(1'b1, 1'b0, 1'b0, 5'h1f, 16'h0);
    #1 chk("rd_o", 16'(rd_o), 16'h0);
    $display("test nonmux done");
  endtask
  task automatic t_single();
    rst(2'h1, 1'b1, 1'b0, 1'b0);
    host_u.lat(1'b0, 16'hbeef);
    host_u.acc(1'b1, 1'b1, 1'b1, 5'h00, 16'h0);
    #1 chk("addr_o", addr_o, 16'hbeef);
    chk("fifo_access_o", 16'(fifo_access_o), 16'h0);
    $display("test single done");
  endtask
  task automatic t_dual();
    rst(2'h2, 1'b0, 1'b1, 1'b0);
    rd_data_i <= 16'h9966;
    host_u.lat(1'b1, 16'hff12);
    host_u.lat(1'b0, 16'haa34);
    host_u.acc(1'b1, 1'b1, 1'b0, 5'h00, 16'h0);
    #1 chk("addr_o", addr_o, 16'h1234);
    chk("data_oe_o", data_oe_o, 16'h00ff);
    chk("data_o", data_o, 16'h0066);
    host_u.acc(1'b0, 1'b1, 1'b0, 5'h00, 16'hbb5c);
    #1 chk("wr_data_o", wr_data_o, 16'h005c);
    $display("test dual done");
  endtask
  // All polarity straps inverted: select, latches and strobes active high
  task automatic t_invert();
    rst(2'h1, 1'b1, 1'b0, 1'b1);
    host_u.lat(1'b0, 16'h4c21);
    host_u.acc(1'b1, 1'b1, 1'b0, 5'h00, 16'h0);
    #1 chk("addr_o", addr_o, 16'h4c21);
    chk("rd_o", 16'(rd_o), 16'h1);
    chk("data_oe_o", data_oe_o, 16'hffff);
    host_u.acc(1'b1, 1'b0, 1'b0, 5'h00, 16'h0);
    #1 chk("rd_o", 16'(rd_o), 16'h0);
    chk("data_oe_o", data_oe_o, 16'h0000);
    $display("test invert done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    t_nonmux();
    t_single();
    t_dual();
    t_invert();
    report_and_stop();
  end
endmodule // tb_top
